// ### slcd_pkg.sv
package slcd_pkg;
	localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B   = 4'h4;
	localparam logic [3:0] ADDR_FRAME    = 4'h8;
	localparam logic [3:0] ADDR_STATUS   = 4'hc;
	localparam int A_ENABLE   = 7;
	localparam int A_LOWPWR   = 6;
	localparam int A_FLAG     = 4;
	localparam int A_INTEN    = 3;
	localparam int A_BLANK    = 0;
	localparam logic [7:0] A_WMASK = 8'hc9;
	localparam logic [7:0] B_WMASK = 8'hf7;
	localparam logic [7:0] F_WMASK = 8'h77;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int B_CLKSEL   = 7;
	localparam int B_HALFBIAS = 6;
	localparam int B_DUTY_LSB = 4;
	localparam int B_PM_LSB   = 0;
	localparam int F_PS_LSB   = 4;
	localparam int F_CD_LSB   = 0;
	localparam int PRESC_W    = 12;
	localparam int K_COUNT_W  = 3;
	localparam logic [2:0] K_STD   = 3'h7;
	localparam logic [2:0] K_THIRD = 3'h5;
	localparam logic [1:0] DUTY_THIRD = 2'h2;
	localparam int SEG_W = 25;
	localparam int COM_W = 4;
endpackage

// ### slcd_frame_ctrl.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module slcd_frame_ctrl
	import slcd_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [3:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic                ext_clk_pin,
	input  wire logic                global_int_enable,
	input  wire logic                vector_taken,
	output logic                     frame_irq,
	output logic                     frame_start,
	output logic                     lcd_active,
	output logic                     blank_active,
	output logic                     lowpwr_active,
	output logic                     half_bias,
	output logic [COM_W-1:0]         common_terminal_en,
	output logic [SEG_W-1:0]         segment_terminal_en,
	output logic                     prescaled_display_clock
);
	import slcd_pkg::*;

	logic [7:0] ctrl_a, ctrl_b, frame_rate;
	logic [7:0] next_ctrl_a, next_ctrl_b, next_frame_rate;
	logic       ext_s1, ext_s2, ext_s3;
	logic [PRESC_W-1:0] presc, next_presc;
	logic [2:0] div_cnt, next_div_cnt;
	logic [2:0] k_cnt, next_k_cnt;
	logic       odd_frame, next_odd_frame;
	logic       lp_work, next_lp_work;
	logic       bl_work, next_bl_work;
	logic       ps_tick, next_ps_tick;
	logic       next_frame_start, next_irq;
	logic [31:0] next_prdata;
	logic [COM_W-1:0] next_com;
	logic [SEG_W-1:0] next_seg;
	logic       lcd_tick, tap, tap_prev, next_tap_prev, frame_end, wr, rd;
	logic [2:0] k_max;

	// external source passes two flops; third flop only feeds edge detect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end
		else
		begin
			ext_s1 <= ext_clk_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign lcd_tick = ctrl_b[B_CLKSEL] ? (ext_s2 && !ext_s3) : 1'b1;

	// tap bit of the prescaler; a falling edge of it is one tap period
	always_comb
	begin
		case (frame_rate[F_PS_LSB +: 3])
			3'h0:    tap = presc[3];
			3'h1:    tap = presc[5];
			3'h2:    tap = presc[6];
			3'h3:    tap = presc[7];
			3'h4:    tap = presc[8];
			3'h5:    tap = presc[9];
			3'h6:    tap = presc[10];
			3'h7:    tap = presc[11];
			default: tap = 1'b0;
		endcase
	end

	assign k_max = (ctrl_b[B_DUTY_LSB +: 2] == DUTY_THIRD) ? K_THIRD : K_STD;
	assign frame_end = ps_tick && (k_cnt >= k_max);

	always_comb
	begin
		next_presc = presc;
		next_tap_prev = tap_prev;
		next_div_cnt = div_cnt;
		next_ps_tick = 1'b0;
		next_k_cnt = k_cnt;
		next_odd_frame = odd_frame;
		next_lp_work = lp_work;
		next_bl_work = bl_work;
		next_frame_start = 1'b0;
		if (!ctrl_a[A_ENABLE])
		begin
			next_presc = '0;
			next_tap_prev = 1'b0;
			next_div_cnt = '0;
			next_k_cnt = '0;
			next_odd_frame = 1'b0;
			next_bl_work = 1'b0;
			next_lp_work = ctrl_a[A_LOWPWR];
		end
		else
		begin
			if (lcd_tick)
				next_presc = presc + 1'b1;
			next_tap_prev = tap;
			if (tap_prev && !tap)
			begin
				if (div_cnt >= frame_rate[F_CD_LSB +: 3])
				begin
					next_div_cnt = '0;
					next_ps_tick = 1'b1;
				end
				else
					next_div_cnt = div_cnt + 1'b1;
			end
			if (ps_tick)
				next_k_cnt = frame_end ? 3'h0 : k_cnt + 1'b1;
			if (frame_end)
			begin
				next_odd_frame = !odd_frame;
				// low-power keeps one data set for two frames
				if (!lp_work || odd_frame)
				begin
					next_lp_work = ctrl_a[A_LOWPWR];
					next_bl_work = ctrl_a[A_BLANK];
					next_odd_frame = 1'b0;
					next_frame_start = 1'b1;
				end
			end
		end
	end

	// register writes; hardware set of the flag beats any clear
	always_comb
	begin
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		next_frame_rate = frame_rate;
		if (wr && paddr == ADDR_CTRL_A)
		begin
			next_ctrl_a = (pwdata[7:0] & A_WMASK) | (ctrl_a & ~A_WMASK);
			if (pwdata[A_FLAG])
				next_ctrl_a[A_FLAG] = 1'b0;
		end
		if (wr && paddr == ADDR_CTRL_B)
			next_ctrl_b = pwdata[7:0] & B_WMASK;
		if (wr && paddr == ADDR_FRAME)
			next_frame_rate = pwdata[7:0] & F_WMASK;
		if (vector_taken)
			next_ctrl_a[A_FLAG] = 1'b0;
		if (next_frame_start)
			next_ctrl_a[A_FLAG] = 1'b1;
		if (!ctrl_a[A_ENABLE])
			next_ctrl_a[A_FLAG] = next_ctrl_a[A_FLAG] & ~next_frame_start;
	end

	always_comb
	begin
		next_prdata = prdata;
		if (rd)
		begin
			case (paddr)
				ADDR_CTRL_A: next_prdata = {24'h0, ctrl_a};
				ADDR_CTRL_B: next_prdata = {24'h0, ctrl_b};
				ADDR_FRAME:  next_prdata = {24'h0, frame_rate};
				ADDR_STATUS: next_prdata = {29'h0, odd_frame, bl_work, lp_work};
				default:     next_prdata = 32'h0;
			endcase
		end
	end

	assign next_irq = ctrl_a[A_FLAG] && ctrl_a[A_INTEN] && global_int_enable;

	// pins in use as display drivers; the rest stay ordinary port pins
	always_comb
	begin
		next_com = '0;
		next_seg = '0;
		if (ctrl_a[A_ENABLE])
		begin
			case (ctrl_b[B_DUTY_LSB +: 2])
				2'h0:    next_com = 4'h1;
				2'h1:    next_com = 4'h3;
				2'h2:    next_com = 4'h7;
				2'h3:    next_com = 4'hf;
				default: next_com = 4'h0;
			endcase
			case (ctrl_b[B_PM_LSB +: 3])
				3'h0:    next_seg = 25'h0001fff;
				3'h1:    next_seg = 25'h0007fff;
				3'h2:    next_seg = 25'h001ffff;
				3'h3:    next_seg = 25'h007ffff;
				3'h4:    next_seg = 25'h01fffff;
				3'h5:    next_seg = 25'h07fffff;
				3'h6:    next_seg = 25'h0ffffff;
				3'h7:    next_seg = 25'h1ffffff;
				default: next_seg = 25'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_a <= CTRL_RESET;
			ctrl_b <= CTRL_RESET;
			frame_rate <= CTRL_RESET;
			presc <= '0;
			tap_prev <= 1'b0;
			div_cnt <= '0;
			ps_tick <= 1'b0;
			k_cnt <= '0;
			odd_frame <= 1'b0;
			lp_work <= 1'b0;
			bl_work <= 1'b0;
			frame_start <= 1'b0;
			frame_irq <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			lcd_active <= 1'b0;
			blank_active <= 1'b0;
			lowpwr_active <= 1'b0;
			half_bias <= 1'b0;
			common_terminal_en <= '0;
			segment_terminal_en <= '0;
			prescaled_display_clock <= 1'b0;
		end
		else
		begin
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
			frame_rate <= next_frame_rate;
			presc <= next_presc;
			tap_prev <= next_tap_prev;
			div_cnt <= next_div_cnt;
			ps_tick <= next_ps_tick;
			k_cnt <= next_k_cnt;
			odd_frame <= next_odd_frame;
			lp_work <= next_lp_work;
			bl_work <= next_bl_work;
			frame_start <= next_frame_start;
			frame_irq <= next_irq;
			prdata <= next_prdata;
			// no wait state: ready registered from the setup phase, high in the first access cycle only
			pready <= psel && !penable;
			pslverr <= 1'b0;
			lcd_active <= ctrl_a[A_ENABLE];
			blank_active <= bl_work && ctrl_a[A_ENABLE];
			lowpwr_active <= lp_work;
			half_bias <= ctrl_b[B_HALFBIAS];
			common_terminal_en <= next_com;
			segment_terminal_en <= next_seg;
			prescaled_display_clock <= next_ps_tick;
		end
	end
endmodule

// ### slcd_glass.sv
`timescale 1ns/10ps
module slcd_glass (
	input  wire logic pclk,
	input  wire logic lcd_active,
	input  wire logic blank_active,
	output logic      unsafe_off
);
	logic was_on = 1'b0;
	logic was_blank = 1'b0;
	initial unsafe_off = 1'b0;
	// glass holds charge unless grounded before the drivers let go
	always @(posedge pclk)
	begin
		was_on <= lcd_active;
		was_blank <= blank_active;
		if (was_on && !lcd_active && !was_blank)
			unsafe_off <= 1'b1;
	end
endmodule

// ### slcd_frame_ctrl_sva.sv
`timescale 1ns/10ps
module slcd_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        global_int_enable,
	input wire logic        frame_irq,
	input wire logic        frame_start,
	input wire logic        lcd_active,
	input wire logic        blank_active,
	input wire logic        lowpwr_active,
	input wire logic [3:0]  common_terminal_en,
	input wire logic [24:0] segment_terminal_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	off_pins_a: assert property (
		!lcd_active && !$past(lcd_active) |-> !common_terminal_en && !segment_terminal_en)
		else $error("pins kept while off");
	off_frame_a: assert property (
		!$past(lcd_active) |-> !frame_start) else $error("frame while off");
	sof_gap_a: assert property (
		frame_start |=> !frame_start [*8]) else $error("frames too close");
	lp_latch_a: assert property (
		$rose(lowpwr_active) && $past(lcd_active) |-> $past(frame_start))
		else $error("waveform mid frame");
	blank_latch_a: assert property (
		$rose(blank_active) |-> $past(frame_start)) else $error("blank mid frame");
	irq_gate_a: assert property (
		frame_irq |-> $past(global_int_enable)) else $error("irq without global enable");
	com_duty_a: assert property (
		lcd_active && $past(lcd_active) |-> common_terminal_en inside {4'h1, 4'h3, 4'h7, 4'hf})
		else $error("bad common set");
	seg_base_a: assert property (
		lcd_active && $past(lcd_active) |-> &segment_terminal_en[12:0]) else $error("base segs off");
endmodule

bind slcd_frame_ctrl slcd_chk slcd_chk_inst (.pclk, .presetn, .global_int_enable, .frame_irq,
	.frame_start, .lcd_active, .blank_active, .lowpwr_active, .common_terminal_en,
	.segment_terminal_en);

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [3:0]  paddr = 4'h0;
	logic [31:0] pwdata = 32'h0;
	logic        global_int_enable = 1'b1;
	logic        vector_taken = 1'b0;
	logic [1:0]  ext_div = 2'h0;
	logic [31:0] prdata, q;
	logic [3:0]  common_terminal_en;
	logic [24:0] segment_terminal_en;
	logic        pready, frame_irq, frame_start, lcd_active;
	logic        pslverr, err, prescaled_display_clock;
	logic        blank_active, lowpwr_active, half_bias, unsafe_off;
	int          n, check_count, n_fail, ps_cnt;
	logic [31:0] rb[3] = '{32'h08, 32'hf7, 32'h77};
	logic [7:0]  bv[5] = '{8'h30, 8'h60, 8'hb0, 8'h10, 8'h00};
	logic [7:0]  fv[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h11};
	int          pv[5] = '{128, 96, 512, 256, 1024};
	always #25 pclk = ~pclk;
	// external source at a quarter of pclk
	always @(posedge pclk) ext_div <= ext_div + 2'h1;
	// prescaled ticks seen since the last frame start
	always @(posedge pclk)
		if (frame_start)
			ps_cnt <= 0;
		else if (prescaled_display_clock)
			ps_cnt <= ps_cnt + 1;
	slcd_frame_ctrl slcd_frame_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .ext_clk_pin(ext_div[1]), .global_int_enable,
		.vector_taken, .frame_irq, .frame_start, .lcd_active, .blank_active, .lowpwr_active,
		.half_bias, .common_terminal_en, .segment_terminal_en, .prescaled_display_clock);
	slcd_glass slcd_glass_inst (.pclk, .lcd_active, .blank_active, .unsafe_off);
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
		q = prdata;
		err = pslverr;
		if (pready !== 1'b1)
		begin
			n_fail++;
			$display("BAD t=%0t no ready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic fwait;
		n = 1;
		@(negedge pclk);
		while (frame_start !== 1'b1 && n < 3000)
		begin
			@(negedge pclk);
			n++;
		end
		if (frame_start !== 1'b1)
		begin
			n_fail++;
			$display("BAD t=%0t no frame start", $time);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#4000000;
		n_fail++;
		stop_test();
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		chk(32'(err), 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, 4'(4 * i), 32'h0);
			chk(q, 32'h0);
			apb(1'b1, 4'(4 * i), i > 0 ? 32'hffffffff : 32'h2e);
			apb(1'b0, 4'(4 * i), 32'h0);
			chk(q, rb[i]);
		end
		$display("regs done");
		apb(1'b1, 4'h8, 32'h0);
		apb(1'b1, 4'h0, 32'h88);
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, 4'h4, 32'h30 | m);
			repeat (2) fwait();
			chk(32'(segment_terminal_en), 32'h1ffffff >> (m < 6 ? 12 - 2 * m : 7 - m));
		end
		$display("mask done");
		// frame lengths run 128, 96, 512, 256, 1024 cycles; >= compares leave no counter past a shorter tap
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 4'h4, 32'(bv[i]));
			apb(1'b1, 4'h8, 32'(fv[i]));
			repeat (3) fwait();
			chk(32'(n), 32'(pv[i]));
			chk(32'(common_terminal_en), (32'h1 << (bv[i][5:4] + 1)) - 1);
			chk(32'(half_bias), 32'(bv[i][6]));
			chk(32'(ps_cnt), bv[i][5:4] == 2'h2 ? 32'd6 : 32'd8);
		end
		$display("rates done");
		fwait();
		apb(1'b0, 4'h0, 32'h0);
		chk(q, 32'h98);
		chk(32'(frame_irq), 32'h1);
		@(posedge pclk) vector_taken <= 1'b1;
		@(posedge pclk) vector_taken <= 1'b0;
		apb(1'b0, 4'h0, 32'h0);
		chk(q, 32'h88);
		fwait();
		apb(1'b1, 4'h0, 32'h88);
		apb(1'b0, 4'h0, 32'h0);
		chk(q, 32'h98);
		apb(1'b1, 4'h0, 32'h98);
		apb(1'b0, 4'h0, 32'h0);
		chk(q, 32'h88);
		@(posedge pclk) global_int_enable <= 1'b0;
		fwait();
		repeat (2) @(negedge pclk);
		chk(32'(frame_irq), 32'h0);
		@(posedge pclk) global_int_enable <= 1'b1;
		$display("flag done");
		apb(1'b1, 4'h0, 32'hc8);
		repeat (3) fwait();
		chk(32'(n), 32'd2048);
		chk(32'(lowpwr_active), 32'h1);
		apb(1'b1, 4'h0, 32'h88);
		repeat (3) fwait();
		@(negedge pclk);
		chk(32'(lowpwr_active), 32'h0);
		$display("lowpower done");
		apb(1'b1, 4'h0, 32'h99);
		fwait();
		// blanking output follows the latched copy one cycle later
		@(negedge pclk);
		chk(32'(blank_active), 32'h1);
		apb(1'b1, 4'h0, 32'h0);
		// status outputs register the control word one cycle after the write
		repeat (3) @(negedge pclk);
		chk(32'(lcd_active), 32'h0);
		chk(32'(common_terminal_en), 32'h0);
		chk(32'(unsafe_off), 32'h0);
		$display("blank done");
		stop_test();
	end
endmodule
